// >>> core/mpcfg_regs.sv
// Master-page configuration registers behind a synchronised serial port
// Notes on behaviour
// R1: The host writes one to bits 6 and 4 of register 0x039 on every write to it.
// R2: The host sets the bias high-impedance bit only with dc-coupled analog inputs.
// R3: Bias bit zero gives direct drive of the resistor common point, one gives series drive.
// R4: Bit 1 of 0x039 gates the channel-B power-down bit of register 0x20.
// R5: Bit 0 of 0x039 at zero enables the sync-input termination, at one disables it.
// R6: Bit 6 of 0x03C enables the programmable SYSREF delay, zero applies none.
// R7: The 5-bit delay code takes bits 4:3 from 0x03C[1:0] and bits 2:0 from 0x05A[7:5].
// R8: The delay moves in 25 ps steps with the first step at 175 ps.
// R9: Code 01000 gives 175 ps and each decrement adds 25 ps down to 00011 at 300 ps.
// R10: Bits 2:0 of 0x03D pick one of eight lane amplitudes, 4 to 7 being the higher ones.
// R11: Channel B powers down when its power-down bit and its gate are both one.
// R12: The host writes zero to reserved bits and reset clears every field.
module mpcfg_regs
  import mpcfg_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       spi_sclk,
  input  wire logic       spi_sen_n,
  input  wire logic       spi_sdin,
  output logic            spi_sdout,
  output logic            spi_sdout_oe,
  input  wire logic       chan_b_powerdown,
  output logic            common_mode_bias_high_impedance,
  output logic            common_mode_reference_direct,
  output logic            chan_b_powerdown_gate,
  output logic            chan_b_powered_down,
  output logic            sync_input_termination_off,
  output logic            sync_input_termination_on,
  output logic            sysref_delay_enable,
  output logic [4:0]      sysref_delay_code,
  output logic            sysref_delay_active,
  output logic            sysref_delay_code_valid,
  output logic [8:0]      sysref_delay_ps,
  output logic [2:0]      lane_output_amplitude,
  output logic            lane_amplitude_high
);
  import mpcfg_pkg::*;

  // Pin synchronisers: three stages, change taken once stages two and three agree
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] lvl_r;
  logic [2:0] agree;
  logic [2:0] rise;
  logic [2:0] fall;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Idle pin levels, so no false edge follows reset
      s1_r  <= SYNC_IDLE;
      s2_r  <= SYNC_IDLE;
      s3_r  <= SYNC_IDLE;
      lvl_r <= SYNC_IDLE;
    end else begin
      s1_r <= {spi_sdin, spi_sen_n, spi_sclk};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 3; i++) begin
        if (agree[i]) begin
          lvl_r[i] <= s3_r[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      agree[i] = (s2_r[i] == s3_r[i]);
      rise[i]  = agree[i] && s3_r[i] && !lvl_r[i];
      fall[i]  = agree[i] && !s3_r[i] && lvl_r[i];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic frame_on;
  logic sdin_lvl;
  assign sclk_rise = rise[0];
  assign sclk_fall = fall[0];
  assign frame_on  = !lvl_r[1] && !fall[1];
  assign sdin_lvl  = agree[2] ? s3_r[2] : lvl_r[2];

  // Frame: read flag, 15-bit address, 8-bit data, most significant bit first
  logic [4:0]            cnt_r;
  logic [FRAME_BITS-2:0] shin_r;
  logic                  rd_r;
  logic [DATA_W-1:0]     shout_r;
  logic                  wr_pulse;
  logic [ADDR_W-1:0]     wr_addr;
  logic [DATA_W-1:0]     wr_data;
  logic [DATA_W-1:0]     rd_data;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r  <= 5'h00;
      shin_r <= '0;
      rd_r   <= 1'b0;
    end else if (!frame_on) begin
      cnt_r <= 5'h00;
      rd_r  <= 1'b0;
    end else if (sclk_rise && cnt_r != CNT_FRAME_END) begin
      cnt_r  <= cnt_r + 5'h01;
      shin_r <= {shin_r[FRAME_BITS-3:0], sdin_lvl};
      if (cnt_r == 5'h00) begin
        rd_r <= sdin_lvl;
      end
    end
  end

  assign wr_pulse = frame_on && sclk_rise && !rd_r && cnt_r == CNT_FRAME_END - 5'h01;
  assign wr_addr  = shin_r[ADDR_W+DATA_W-2:DATA_W-1];
  assign wr_data  = {shin_r[DATA_W-2:0], sdin_lvl};

  // Read shifter: loaded after the address, shifted on each falling clock from the seventeenth rise on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shout_r <= RST_VAL;
    end else if (frame_on && rd_r && sclk_rise && cnt_r == CNT_ADDR_DONE - 5'h01) begin
      shout_r <= rd_data;
    end else if (frame_on && rd_r && sclk_fall && cnt_r > CNT_ADDR_DONE) begin
      shout_r <= {shout_r[DATA_W-2:0], 1'b0};
    end
  end

  logic oe_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= frame_on && rd_r && cnt_r >= CNT_ADDR_DONE;
    end
  end
  assign spi_sdout    = shout_r[DATA_W-1];
  assign spi_sdout_oe = oe_r;

  // Storage: only read/write fields are held; reserved and write-only bits drop
  logic       cm_hiz_r;
  logic       chb_gate_r;
  logic       sync_off_r;
  logic       sref_en_r;
  logic [1:0] sref_hi_r;
  logic [2:0] sref_lo_r;
  logic [2:0] amp_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cm_hiz_r <= 1'b0; // R12
    end else if (wr_pulse && wr_addr == ADDR_CM_BIAS) begin
      cm_hiz_r <= wr_data[BIT_CM_HIGH_Z];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chb_gate_r <= 1'b0; // R12
      sync_off_r <= 1'b0;
    end else if (wr_pulse && wr_addr == ADDR_CHB_SYNC) begin
      chb_gate_r <= wr_data[BIT_CHB_GATE]; // R4
      sync_off_r <= wr_data[BIT_SYNC_TOFF]; // R5
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sref_en_r <= 1'b0; // R12
      sref_hi_r <= RST_2;
    end else if (wr_pulse && wr_addr == ADDR_SREF_HIGH) begin
      sref_en_r <= wr_data[BIT_SREF_EN]; // R6
      sref_hi_r <= wr_data[1:0]; // R7
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sref_lo_r <= RST_3; // R12
    end else if (wr_pulse && wr_addr == ADDR_SREF_LOW) begin
      sref_lo_r <= wr_data[DATA_W-1:DATA_W-3]; // R7
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amp_r <= RST_3; // R12
    end else if (wr_pulse && wr_addr == ADDR_LANE_AMP) begin
      amp_r <= wr_data[2:0]; // R10
    end
  end

  always_comb begin
    rd_data = RST_VAL;
    // Address complete at the sixteenth rise: fourteen bits held plus the live one
    case ({shin_r[ADDR_W-2:0], sdin_lvl})
      ADDR_CM_BIAS:   rd_data[BIT_CM_HIGH_Z] = cm_hiz_r;
      ADDR_CHB_SYNC:  rd_data = {6'h00, chb_gate_r, sync_off_r};
      ADDR_SREF_HIGH: rd_data = {1'b0, sref_en_r, 4'h0, sref_hi_r};
      ADDR_LANE_AMP:  rd_data = {5'h00, amp_r};
      ADDR_SREF_LOW:  rd_data = {sref_lo_r, 5'h00};
      default:        rd_data = RST_VAL;
    endcase
  end

  // Control outputs
  logic [4:0] code;
  logic       code_ok;
  assign code    = {sref_hi_r, sref_lo_r}; // R7
  assign code_ok = code <= CODE_FIRST_STEP && code >= CODE_LAST_STEP; // R9

  assign common_mode_bias_high_impedance = cm_hiz_r; // R3
  assign common_mode_reference_direct    = !cm_hiz_r; // R3
  assign chan_b_powerdown_gate           = chb_gate_r;
  assign chan_b_powered_down             = chb_gate_r && chan_b_powerdown; // R11
  assign sync_input_termination_off      = sync_off_r;
  assign sync_input_termination_on       = !sync_off_r; // R5
  assign sysref_delay_enable             = sref_en_r;
  assign sysref_delay_code               = code;
  assign sysref_delay_active             = sref_en_r && code_ok; // R6
  assign sysref_delay_code_valid         = code_ok;
  assign lane_output_amplitude           = amp_r;
  assign lane_amplitude_high             = amp_r[BIT_AMP_HIGH]; // R10

  // Nominal delay: first step plus one fine step per code decrement
  logic [8:0] delay_ps_nxt;
  logic [8:0] delay_ps_r;

  always_comb begin
    delay_ps_nxt = 9'h000;
    if (sref_en_r && code_ok) begin
      delay_ps_nxt = FIRST_STEP_PS
        + 9'(FINE_STEP_PS * 9'(CODE_FIRST_STEP - code)); // R8 R9
    end
  end

  // Registered so the delay word downstream only moves on a clock edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      delay_ps_r <= '0; // R12
    end else begin
      delay_ps_r <= delay_ps_nxt;
    end
  end
  assign sysref_delay_ps = delay_ps_r;

  // Checks
  // Write path into the stored fields
  a_hiz_write: assert property (@(posedge clock) disable iff (rst) // R3
    wr_pulse && wr_addr == ADDR_CM_BIAS |=> cm_hiz_r == $past(wr_data[BIT_CM_HIGH_Z]))
    else $error("bias impedance bit not stored");
  a_gate_write: assert property (@(posedge clock) disable iff (rst) // R4
    wr_pulse && wr_addr == ADDR_CHB_SYNC
    |=> chan_b_powerdown_gate == $past(wr_data[BIT_CHB_GATE]))
    else $error("power-down gate bit not stored");
  a_term_sense: assert property (@(posedge clock) disable iff (rst) // R5
    wr_pulse && wr_addr == ADDR_CHB_SYNC |=> sync_input_termination_on == !$past(wr_data[0]))
    else $error("termination sense wrong");
  a_high_write: assert property (@(posedge clock) disable iff (rst) // R6 R7
    wr_pulse && wr_addr == ADDR_SREF_HIGH
    |=> sysref_delay_enable == $past(wr_data[BIT_SREF_EN])
      && sysref_delay_code[4:3] == $past(wr_data[1:0]))
    else $error("delay enable or high code bits not stored");
  a_code_join: assert property (@(posedge clock) disable iff (rst) // R7
    wr_pulse && wr_addr == ADDR_SREF_LOW |=> sysref_delay_code[2:0] == $past(wr_data[7:5]))
    else $error("low code bits not from bits 7:5");
  a_amp_store: assert property (@(posedge clock) disable iff (rst) // R10
    wr_pulse && wr_addr == ADDR_LANE_AMP |=> lane_output_amplitude == $past(wr_data[2:0]))
    else $error("amplitude field not stored");
  // Derived controls
  a_hiz_sense: assert property (@(posedge clock) disable iff (rst) // R3
    common_mode_reference_direct != common_mode_bias_high_impedance)
    else $error("bias drive selects disagree");
  a_chb_gate: assert property (@(posedge clock) disable iff (rst) // R4
    chan_b_powered_down == (chb_gate_r && chan_b_powerdown))
    else $error("channel B power-down not gated");
  a_chb_off: assert property (@(posedge clock) disable iff (rst) // R11
    !chb_gate_r |-> !chan_b_powered_down)
    else $error("channel B down without gate");
  a_chb_down: assert property (@(posedge clock) disable iff (rst) // R11
    chb_gate_r && chan_b_powerdown |-> chan_b_powered_down)
    else $error("channel B not powered down");
  a_term_pair: assert property (@(posedge clock) disable iff (rst) // R5
    sync_input_termination_on != sync_input_termination_off)
    else $error("termination selects disagree");
  a_delay_off: assert property (@(posedge clock) disable iff (rst) // R6
    !sref_en_r |-> !sysref_delay_active ##1 sysref_delay_ps == 9'h000)
    else $error("delay applied while disabled");
  a_first_step: assert property (@(posedge clock) disable iff (rst) // R8
    sref_en_r && code == 5'h08 |=> sysref_delay_ps == 9'h0AF)
    else $error("first step not 175 ps");
  a_step_grid: assert property (@(posedge clock) disable iff (rst) // R8
    sysref_delay_active |=> (sysref_delay_ps - 9'h0AF) % 9'h019 == 9'h000)
    else $error("delay off the 25 ps grid");
  a_last_step: assert property (@(posedge clock) disable iff (rst) // R9
    sref_en_r && code == 5'h03 |=> sysref_delay_ps == 9'h12C)
    else $error("last step not 300 ps");
  a_delay_range: assert property (@(posedge clock) disable iff (rst) // R9
    sysref_delay_active |=> sysref_delay_ps >= 9'h0AF && sysref_delay_ps <= 9'h12C)
    else $error("delay outside 175 to 300 ps");
  a_amp_high: assert property (@(posedge clock) disable iff (rst) // R10
    lane_amplitude_high == (lane_output_amplitude >= 3'h4))
    else $error("amplitude class wrong");
  a_oe_frame: assert property (@(posedge clock) disable iff (rst)
    !frame_on |=> !spi_sdout_oe)
    else $error("read driver on outside a frame");
  a_reset_clear: assert property (@(posedge clock) // R12
    $fell(rst) |-> amp_r == 3'h0 && code == 5'h00 && !cm_hiz_r && !chb_gate_r
      && sysref_delay_ps == 9'h000 && !spi_sdout_oe)
    else $error("fields not cleared by reset");
endmodule

// >>> include/mpcfg_pkg.sv
// Register map, field positions and serial frame layout of the master-page bank
package mpcfg_pkg;
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FRAME_BITS = 24;
  localparam logic [4:0]  CNT_ADDR_DONE = 5'h10;
  localparam logic [4:0]  CNT_FRAME_END = 5'h18;

  localparam logic [ADDR_W-1:0] ADDR_CM_BIAS   = 15'h0032;
  localparam logic [ADDR_W-1:0] ADDR_CHB_SYNC  = 15'h0039;
  localparam logic [ADDR_W-1:0] ADDR_SREF_HIGH = 15'h003C;
  localparam logic [ADDR_W-1:0] ADDR_LANE_AMP  = 15'h003D;
  localparam logic [ADDR_W-1:0] ADDR_SREF_LOW  = 15'h005A;

  localparam int unsigned BIT_CM_HIGH_Z   = 5;
  localparam int unsigned BIT_CHB_GATE    = 1;
  localparam int unsigned BIT_SYNC_TOFF   = 0;
  localparam int unsigned BIT_SREF_EN     = 6;
  localparam int unsigned BIT_AMP_HIGH    = 2;

  localparam logic [DATA_W-1:0] RST_VAL   = 8'h00;
  localparam logic [1:0]        RST_2     = 2'h0;
  localparam logic [2:0]        RST_3     = 3'h0;
  localparam logic [2:0]        SYNC_IDLE = 3'h2;

  localparam logic [4:0] CODE_FIRST_STEP = 5'h08;
  localparam logic [4:0] CODE_LAST_STEP  = 5'h03;
  localparam logic [8:0] FIRST_STEP_PS   = 9'h0AF;
  localparam logic [8:0] FINE_STEP_PS    = 9'h019;
endpackage

// >>> test/mpcfg_host.sv
// Serial configuration host model driving the bank's serial port
module mpcfg_host (
  input  wire logic clock,
  output logic      spi_sclk,
  output logic      spi_sen_n,
  output logic      spi_sdin,
  input  wire logic spi_sdout,
  input  wire logic spi_sdout_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    spi_sclk  = 1'h0;
    spi_sen_n = 1'h1;
    spi_sdin  = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // One 24-bit frame, msb first; each sclk phase lasts 6 clocks
  task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd,
                      output logic [7:0] rdat, output logic oe);
    logic [23:0] f;
    f = {rd, addr, wd};
    rdat = 8'h00;
    oe = 1'h0;
    spi_sen_n = 1'h0;
    for (int k = 0; k < 24; k++) begin
      spi_sdin = f[23-k];
      tick(6);
      if (k >= 16) rdat = {rdat[6:0], spi_sdout};
      if (k == 16) oe = spi_sdout_oe;
      spi_sclk = 1'h1;
      tick(6);
      spi_sclk = 1'h0;
    end
    tick(2);
    spi_sen_n = 1'h1;
    // Released data line no longer shows the last bit
    spi_sdin = ~spi_sdin;
    tick(6);
  endtask
endmodule

// >>> test/mpcfg_regs_tb.sv
// Self-checking bench of the master-page configuration bank
module mpcfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mpcfg_pkg::*;

  logic       clock = 1'h0;
  logic       rst = 1'h1;
  logic       chan_b_powerdown = 1'h0;
  logic       spi_sclk, spi_sen_n, spi_sdin, spi_sdout, spi_sdout_oe;
  logic       common_mode_bias_high_impedance, common_mode_reference_direct;
  logic       chan_b_powerdown_gate, chan_b_powered_down;
  logic       sync_input_termination_off, sync_input_termination_on;
  logic       sysref_delay_enable, sysref_delay_active, sysref_delay_code_valid;
  logic [4:0] sysref_delay_code;
  logic [8:0] sysref_delay_ps;
  logic [2:0] lane_output_amplitude;
  logic       lane_amplitude_high;
  logic       v;
  logic [8:0] ps_exp;
  int         n_fail = 0;
  int         checked = 0;

  always #25 clock = ~clock;

  mpcfg_regs mpcfg_regs_i (.clock, .rst, .spi_sclk, .spi_sen_n, .spi_sdin, .spi_sdout,
    .spi_sdout_oe, .chan_b_powerdown, .common_mode_bias_high_impedance,
    .common_mode_reference_direct, .chan_b_powerdown_gate, .chan_b_powered_down,
    .sync_input_termination_off, .sync_input_termination_on, .sysref_delay_enable,
    .sysref_delay_code, .sysref_delay_active, .sysref_delay_code_valid, .sysref_delay_ps,
    .lane_output_amplitude, .lane_amplitude_high);

  mpcfg_host mpcfg_host_i (.clock, .spi_sclk, .spi_sen_n, .spi_sdin, .spi_sdout,
    .spi_sdout_oe);

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       o;
    if (a == ADDR_CHB_SYNC) d = d | 8'h50;
    mpcfg_host_i.xfer(1'h0, a, d, q, o);
    chk(o, 9'h0);
  endtask

  task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       o;
    mpcfg_host_i.xfer(1'h1, a, 8'h00, q, o);
    chk({1'h0, q}, {1'h0, exp});
    chk(o, 9'h1);
  endtask

  initial begin
    repeat (8) @(negedge clock);
    rst = 1'h0;
    repeat (5) @(negedge clock);
    chk(common_mode_bias_high_impedance, 9'h0); chk(common_mode_reference_direct, 9'h1);
    chk(sync_input_termination_on, 9'h1); chk(sysref_delay_ps, 9'h0);
    chk(spi_sdout_oe, 9'h0);
    chk(spi_sdout, 9'h0);
    // Inputs taken as dc-coupled here
    wr(ADDR_CM_BIAS, 8'h20);
    chk(common_mode_bias_high_impedance, 9'h1); chk(common_mode_reference_direct, 9'h0);
    rdchk(ADDR_CM_BIAS, 8'h20);
    wr(ADDR_CHB_SYNC, 8'h03);
    rdchk(ADDR_CHB_SYNC, 8'h03);
    chk(sync_input_termination_off, 9'h1); chk(sync_input_termination_on, 9'h0);
    chan_b_powerdown = 1'h1;
    @(negedge clock);
    chk(chan_b_powered_down, 9'h1);
    wr(ADDR_CHB_SYNC, 8'h00);
    chk(chan_b_powerdown_gate, 9'h0); chk(chan_b_powered_down, 9'h0);
    chan_b_powerdown = 1'h0;
    wr(ADDR_CHB_SYNC, 8'h02);
    chk(chan_b_powerdown_gate, 9'h1); chk(chan_b_powered_down, 9'h0);
    for (int c = 2; c <= 9; c++) begin
      for (int e = 0; e < 2; e++) begin
        wr(ADDR_SREF_HIGH, {1'h0, e[0], 4'h0, c[4:3]});
        wr(ADDR_SREF_LOW, {c[2:0], 5'h00});
        v = (e == 1 && c >= 3 && c <= 8);
        chk(sysref_delay_code, c[4:0]); chk(sysref_delay_enable, e[0]);
        chk(sysref_delay_code_valid, (c >= 3 && c <= 8)); chk(sysref_delay_active, v);
        ps_exp = v ? 9'h0AF + 9'h019 * 9'(4'h8 - c[3:0]) : 9'h000;
        chk(sysref_delay_ps, ps_exp);
      end
    end
    rdchk(ADDR_SREF_HIGH, 8'h41); rdchk(ADDR_SREF_LOW, 8'h20);
    for (int a = 0; a < 8; a++) begin
      wr(ADDR_LANE_AMP, 8'(a));
      chk(lane_output_amplitude, a[2:0]); chk(lane_amplitude_high, a[2]);
    end
    rdchk(ADDR_LANE_AMP, 8'h07);
    // Unmapped place ignores writes and reads zero
    wr(15'h0033, 8'hFF);
    rdchk(15'h0033, 8'h00);
    rst = 1'h1;
    @(negedge clock);
    rst = 1'h0;
    repeat (5) @(negedge clock);
    chk(lane_output_amplitude, 9'h0); chk(sysref_delay_enable, 9'h0);
    chk(common_mode_bias_high_impedance, 9'h0); chk(chan_b_powerdown_gate, 9'h0);
    chk(sysref_delay_ps, 9'h0);
    chk(spi_sdout_oe, 9'h0);
    rdchk(ADDR_SREF_LOW, 8'h00);
    results;
  end

  // Hang guard
  initial begin
    repeat (60000) @(negedge clock);
    n_fail++;
    results;
  end
endmodule
